// >>> logic/gamma_pkg.sv
// Constants, types and helpers shared by the gamma reference target logic
// Behaviour
// (R01) Master writes a pointer byte, top bits 00, low six bits pick register.
// (R02) Data held and returned only for channels, 0x12, 0x13 and 0x3C-0x3F; code reads 0x3E as zero.
// (R03) Unused pointers 0x10, 0x11 and 0x14-0x17 read back as zero.
// (R04) After pointer, repeated start and read address; device acknowledges it.
// (R05) Read data is two bytes, high first; channel codes use low ten bits.
// (R06) Master acks first read byte, ends by nack, stop or start.
// (R07) Multiple read advances pointer after each acknowledged byte pair.
// (R08) Identity and write-count registers are read only singly by master.
// (R09) One nonvolatile word per transaction; further words are refused.
// (R10) Nonvolatile writes accept only gamma channels and the two common ones.
// (R11) Top data bits 01 select nonvolatile write; code is low ten bits.
// (R12) Word commits after second data byte; early stop or start aborts.
// (R13) Nonvolatile write loads register and output at once.
// (R14) Programming lasts up to 250 us; bus stays quiet meanwhile.
// (R15) Master acquires stored values first, then reads channel normally.
// (R16) Bank pin change reloads all 18 channels together after 750 us.
// (R17) Bank pin switches the active curve between bank zero and bank one.
// (R18) Channel write with bit 15 clear updates only the input register.
// (R19) Channel write with bit 15 set moves all inputs to outputs at once.
// (R20) Master writes all channels with bit 15 clear, then one with it set.
// (R21) Target address is 111010 plus the address-select pin level.
// (R22) Bank pin low picks bank zero, high bank one; power-up level counts.
// (R23) Pointer top bits 10 acquire all channels, 01 the addressed channel.
// (R24) Top two data bits choose volatile or nonvolatile write.
// (R25) Programming busy interval timed by own clock, at least 250 us.
// (R26) Bank reload delay timed by own clock, then all channels update.
package gamma_pkg;
  localparam int CLK_NS = 100;
  localparam int NVM_PROG_NS = 250000;
  localparam int NVM_PROG_CYC = (NVM_PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int BANK_LOAD_NS = 750000;
  localparam int BANK_LOAD_CYC = BANK_LOAD_NS / CLK_NS;
  localparam int ONE_ACQ_NS = 36000;
  localparam int ONE_ACQ_CYC = ONE_ACQ_NS / CLK_NS;
  localparam logic [13:0] POWERUP_CYC = 14'h0004;
  localparam int NCHAN = 20;
  localparam logic [4:0] LAST_IDX = 5'h13;
  localparam logic [9:0] CODE_DEFAULT = 10'h200;
  localparam logic [4:0] MAX_WRITES = 5'h10;
  localparam logic [5:0] PTR_LAST_GAMMA = 6'h0F;
  localparam logic [5:0] PTR_VCOM_ONE = 6'h12;
  localparam logic [5:0] PTR_VCOM_TWO = 6'h13;
  localparam logic [5:0] PTR_DIE_REV = 6'h3C;
  localparam logic [5:0] PTR_DIE_ID = 6'h3D;
  localparam logic [5:0] PTR_WCOUNT = 6'h3F;
  localparam logic [5:0] DEV_ADDR_HI = 6'h3A;
  localparam logic [7:0] GEN_CALL_BYTE = 8'h00;
  localparam logic [7:0] GEN_RESET_BYTE = 8'h06;
  localparam logic [1:0] CMD_REG = 2'h0;
  localparam logic [1:0] CMD_ONE_ACQ = 2'h1;
  localparam logic [1:0] CMD_ALL_ACQ = 2'h2;
  localparam logic [1:0] NVM_WRITE_SEL = 2'h1;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Arbitrary identity values
  localparam logic [15:0] DIE_ID_VAL = 16'h0A5C;
  localparam logic [15:0] DIE_REV_VAL = 16'h0001;

  typedef logic [9:0] code_t;
  typedef struct packed {
    code_t [15:0] gamma;
    code_t [1:0] vcom;
  } chan_out_s;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } i2c_state_e;

  function automatic logic chan_ok(input logic [5:0] p);
    chan_ok = (p <= PTR_LAST_GAMMA) || (p == PTR_VCOM_ONE) ||
              (p == PTR_VCOM_TWO);
  endfunction : chan_ok
endpackage : gamma_pkg

// >>> logic/nvm_store.sv
// Two-bank nonvolatile word store with per-word write counts
`timescale 1ns/1ns
module nvm_store
  import gamma_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Write port
  input wire logic wr_en,
  input wire logic wr_bank,
  input wire logic [4:0] wr_idx,
  input wire code_t wr_code,
  // Read port
  input wire logic rd_bank,
  input wire logic [4:0] rd_idx,
  output code_t rd_code,
  output logic [4:0] rd_count
);
  code_t mem [2][NCHAN];
  logic [4:0] count_reg [2][NCHAN];

  genvar b, i;
  generate
    for (b = 0; b < 2; b++) begin : g_bank
      for (i = 0; i < NCHAN; i++) begin : g_word
        // Wear limit: writes past the last rewrite are dropped
        always_ff @(posedge clock or negedge rstn) begin
          if (!rstn) begin
            count_reg[b][i] <= 5'h00;
          end else if (wr_en && wr_bank == b && wr_idx == i &&
                       count_reg[b][i] != MAX_WRITES) begin
            count_reg[b][i] <= count_reg[b][i] + 5'h01;
          end
        end
        always_ff @(posedge clock) begin
          if (wr_en && wr_bank == b && wr_idx == i &&
              count_reg[b][i] != MAX_WRITES) begin
            mem[b][i] <= wr_code;
          end
        end
      end
    end
  endgenerate

  // Unprogrammed words read as mid-scale
  always_comb begin
    rd_code = CODE_DEFAULT;
    rd_count = 5'h00;
    if (rd_idx <= LAST_IDX) begin
      rd_count = count_reg[rd_bank][rd_idx];
      if (rd_count != 5'h00) begin
        rd_code = mem[rd_bank][rd_idx];
      end
    end
  end
endmodule : nvm_store

// >>> logic/gamma_target.sv
// Serial target, channel registers and nonvolatile sequencing
`timescale 1ns/1ns
module gamma_target
  import gamma_pkg::*;
#(
  parameter int BANK_LOAD_CYCLES = BANK_LOAD_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Straps
  input wire logic address_select_pin,
  input wire logic bank_select_pin,
  // Channel codes and status
  output chan_out_s chan_out,
  output logic nvm_busy
);
  logic [3:0] meta_reg, sync_reg;
  logic scl_d_reg, sda_d_reg;
  i2c_state_e state_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shift_reg, tx_reg, msb_reg;
  logic rw_reg, gc_reg, nack_reg, sent_lo_reg, nvm_done_reg;
  logic [1:0] phase_reg, cmd_reg;
  logic cmd_valid_reg;
  logic [5:0] ptr_reg, wr_ptr_reg;
  code_t wr_code_reg;
  logic vol_pulse_reg, nvm_pulse_reg, xfer_reg, acq_pulse_reg;
  logic acq_all_reg, soft_rst_reg;
  logic [11:0] busy_cnt_reg;
  logic pend_reg, pend_all_reg, walk_reg, walk_all_reg, primed_reg;
  logic bank_prev_reg;
  logic [13:0] pend_cnt_reg;
  logic [4:0] walk_idx_reg, acq_idx_reg, max_reg;
  logic [3:0] wcount_reg;
  code_t in_reg [NCHAN];
  code_t out_reg [NCHAN];
  code_t rd_code, load_code;
  logic [4:0] rd_count, load_idx, cnt_now;
  logic scl, sda, asel, bank;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic [15:0] rd_word;
  logic load_en, walk_last, xfer_all, out_one;

  // Pin synchronisers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 4'hF;
      sync_reg <= 4'hF;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      meta_reg <= {bank_select_pin, address_select_pin, sda_in, scl_in};
      sync_reg <= meta_reg;
      scl_d_reg <= sync_reg[0];
      sda_d_reg <= sync_reg[1];
    end
  end

  assign scl = sync_reg[0];
  assign sda = sync_reg[1];
  assign asel = sync_reg[2];
  assign bank = sync_reg[3];
  assign scl_rise = scl & ~scl_d_reg;
  assign scl_fall = ~scl & scl_d_reg;
  assign start_det = scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop_det = scl & scl_d_reg & ~sda_d_reg & sda;
  assign sda_out = 1'b0;

  always_comb begin
    rd_word = 16'h0000; // R03
    if (chan_ok(ptr_reg)) begin
      rd_word = {6'h00, in_reg[ptr_reg[4:0]]}; // R02 R05
    end else if (ptr_reg == PTR_DIE_REV) begin
      rd_word = DIE_REV_VAL;
    end else if (ptr_reg == PTR_DIE_ID) begin
      rd_word = DIE_ID_VAL;
    end else if (ptr_reg == PTR_WCOUNT) begin
      rd_word = {12'h000, wcount_reg};
    end
  end

  // Serial protocol engine
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      msb_reg <= 8'h00;
      rw_reg <= 1'b0;
      gc_reg <= 1'b0;
      nack_reg <= 1'b1;
      sent_lo_reg <= 1'b0;
      nvm_done_reg <= 1'b0;
      phase_reg <= 2'h0;
      cmd_reg <= CMD_REG;
      cmd_valid_reg <= 1'b0;
      ptr_reg <= 6'h00;
      wr_ptr_reg <= 6'h00;
      wr_code_reg <= CODE_DEFAULT;
      vol_pulse_reg <= 1'b0;
      nvm_pulse_reg <= 1'b0;
      xfer_reg <= 1'b0;
      acq_pulse_reg <= 1'b0;
      acq_all_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      vol_pulse_reg <= 1'b0;
      nvm_pulse_reg <= 1'b0;
      acq_pulse_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
      if (start_det || stop_det) begin
        if (stop_det && cmd_valid_reg) begin
          acq_pulse_reg <= 1'b1; // R23
          acq_all_reg <= (cmd_reg == CMD_ALL_ACQ);
        end
        state_reg <= start_det ? ST_ADDR : ST_IDLE;
        bitcnt_reg <= 4'h0;
        phase_reg <= 2'h0; // R12
        cmd_valid_reg <= 1'b0;
        nvm_done_reg <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        if (state_reg == ST_ADDR || state_reg == ST_WR) begin
          shift_reg <= {shift_reg[6:0], sda};
          bitcnt_reg <= bitcnt_reg + 4'h1;
        end else if (state_reg == ST_ACK_RD) begin
          nack_reg <= sda;
          if (!sda && sent_lo_reg) begin
            ptr_reg <= ptr_reg + 6'h01; // R07
          end
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: begin
            if (bitcnt_reg == BITS_PER_BYTE) begin
              bitcnt_reg <= 4'h0;
              if (busy_cnt_reg == 12'h000 &&
                  (shift_reg[7:1] == {DEV_ADDR_HI, asel} ||
                   shift_reg == GEN_CALL_BYTE)) begin // R21 R04
                sda_oe_n <= 1'b0;
                rw_reg <= shift_reg[0];
                gc_reg <= (shift_reg == GEN_CALL_BYTE);
                state_reg <= ST_ACK_ADDR;
              end else begin
                state_reg <= ST_IDLE; // R14
              end
            end
          end
          ST_ACK_ADDR: begin
            if (rw_reg) begin
              sda_oe_n <= rd_word[15];
              tx_reg <= {rd_word[14:8], 1'b0};
              sent_lo_reg <= 1'b0;
              bitcnt_reg <= 4'h1;
              state_reg <= ST_RD;
            end else begin
              sda_oe_n <= 1'b1;
              state_reg <= ST_WR;
            end
          end
          ST_WR: begin
            if (bitcnt_reg == BITS_PER_BYTE) begin
              bitcnt_reg <= 4'h0;
              state_reg <= ST_ACK_WR;
              sda_oe_n <= 1'b0;
              if (gc_reg) begin
                if (shift_reg == GEN_RESET_BYTE) begin
                  soft_rst_reg <= 1'b1;
                end else begin
                  sda_oe_n <= 1'b1;
                  state_reg <= ST_IDLE;
                end
              end else if (phase_reg == 2'h0) begin
                ptr_reg <= shift_reg[5:0]; // R01
                cmd_reg <= shift_reg[7:6];
                cmd_valid_reg <= (shift_reg[7:6] == CMD_ONE_ACQ) ||
                                 (shift_reg[7:6] == CMD_ALL_ACQ); // R23
                phase_reg <= 2'h1;
              end else if (phase_reg == 2'h1) begin
                msb_reg <= shift_reg;
                phase_reg <= 2'h2;
                if (nvm_done_reg) begin
                  sda_oe_n <= 1'b1; // R09
                  state_reg <= ST_IDLE;
                end
              end else begin
                phase_reg <= 2'h1;
                ptr_reg <= ptr_reg + 6'h01;
                wr_ptr_reg <= ptr_reg;
                wr_code_reg <= {msb_reg[1:0], shift_reg}; // R11
                if (msb_reg[7:6] == NVM_WRITE_SEL) begin // R24
                  if (chan_ok(ptr_reg) && !nvm_done_reg) begin // R10
                    nvm_pulse_reg <= 1'b1; // R12
                    nvm_done_reg <= 1'b1; // R09
                  end
                end else begin
                  vol_pulse_reg <= 1'b1;
                  xfer_reg <= msb_reg[7]; // R18 R19
                end
              end
            end
          end
          ST_ACK_WR: begin
            sda_oe_n <= 1'b1;
            state_reg <= ST_WR;
          end
          ST_RD: begin
            if (bitcnt_reg == BITS_PER_BYTE) begin
              sda_oe_n <= 1'b1;
              state_reg <= ST_ACK_RD;
            end else begin
              sda_oe_n <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bitcnt_reg <= bitcnt_reg + 4'h1;
            end
          end
          ST_ACK_RD: begin
            if (nack_reg) begin
              state_reg <= ST_IDLE;
            end else begin
              sent_lo_reg <= ~sent_lo_reg;
              sda_oe_n <= sent_lo_reg ? rd_word[15] : rd_word[7]; // R05
              tx_reg <= sent_lo_reg ? {rd_word[14:8], 1'b0} :
                                      {rd_word[6:0], 1'b0};
              bitcnt_reg <= 4'h1;
              state_reg <= ST_RD;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Programming busy interval
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_cnt_reg <= 12'h000;
      nvm_busy <= 1'b0;
    end else if (nvm_pulse_reg) begin
      busy_cnt_reg <= 12'(NVM_PROG_CYC); // R25 R14
      nvm_busy <= 1'b1;
    end else if (busy_cnt_reg != 12'h000) begin
      busy_cnt_reg <= busy_cnt_reg - 12'h001;
      nvm_busy <= (busy_cnt_reg != 12'h001);
    end
  end

  // Reload scheduling and bank walk
  assign cnt_now = (walk_all_reg && max_reg > rd_count) ? max_reg : rd_count;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend_reg <= 1'b1;
      pend_all_reg <= 1'b1;
      pend_cnt_reg <= POWERUP_CYC;
      walk_reg <= 1'b0;
      walk_all_reg <= 1'b0;
      walk_idx_reg <= 5'h00;
      acq_idx_reg <= 5'h00;
      max_reg <= 5'h00;
      wcount_reg <= 4'h0;
      primed_reg <= 1'b0;
      bank_prev_reg <= 1'b0;
    end else begin
      bank_prev_reg <= bank;
      if (soft_rst_reg) begin
        pend_reg <= 1'b1;
        pend_all_reg <= 1'b1;
        pend_cnt_reg <= POWERUP_CYC;
        primed_reg <= 1'b0;
      end else if (primed_reg && bank != bank_prev_reg) begin
        pend_reg <= 1'b1; // R16 R17
        pend_all_reg <= 1'b1;
        pend_cnt_reg <= 14'(BANK_LOAD_CYCLES); // R26
      end else if (acq_pulse_reg) begin
        pend_reg <= 1'b1;
        pend_all_reg <= acq_all_reg;
        acq_idx_reg <= ptr_reg[4:0];
        pend_cnt_reg <= acq_all_reg ? 14'(BANK_LOAD_CYCLES) :
                                      14'(ONE_ACQ_CYC);
      end else if (pend_reg) begin
        if (pend_cnt_reg <= 14'h0001) begin
          pend_reg <= 1'b0;
          walk_reg <= 1'b1;
          walk_all_reg <= pend_all_reg;
          walk_idx_reg <= pend_all_reg ? 5'h00 : acq_idx_reg;
          max_reg <= 5'h00;
          primed_reg <= 1'b1; // R22
        end else begin
          pend_cnt_reg <= pend_cnt_reg - 14'h0001;
        end
      end
      if (walk_reg) begin
        max_reg <= cnt_now;
        walk_idx_reg <= walk_idx_reg + 5'h01;
        if (walk_last) begin
          walk_reg <= 1'b0;
          wcount_reg <= (cnt_now == 5'h00) ? 4'h0 :
                        4'(cnt_now - 5'h01);
        end
      end
    end
  end

  assign walk_last = walk_reg & (~walk_all_reg | walk_idx_reg == LAST_IDX);
  assign load_en = walk_reg | nvm_pulse_reg |
                   (vol_pulse_reg & chan_ok(wr_ptr_reg));
  assign load_idx = walk_reg ? walk_idx_reg : wr_ptr_reg[4:0];
  assign load_code = walk_reg ? rd_code : wr_code_reg;
  assign xfer_all = (walk_last & walk_all_reg) |
                    (~walk_reg & vol_pulse_reg & xfer_reg); // R19 R16
  assign out_one = (walk_last & ~walk_all_reg) |
                   (~walk_reg & nvm_pulse_reg); // R13

  nvm_store u_store (
    .clock(clock),
    .rstn(rstn),
    .wr_en(nvm_pulse_reg & ~walk_reg),
    .wr_bank(bank),
    .wr_idx(wr_ptr_reg[4:0]),
    .wr_code(wr_code_reg),
    .rd_bank(bank), // R17 R22
    .rd_idx(walk_idx_reg),
    .rd_code(rd_code),
    .rd_count(rd_count)
  );

  // Double-buffered channel registers
  genvar c;
  generate
    for (c = 0; c < NCHAN; c++) begin : g_chan
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          in_reg[c] <= CODE_DEFAULT;
          out_reg[c] <= CODE_DEFAULT;
        end else begin
          if (load_en && load_idx == c) begin
            in_reg[c] <= load_code; // R18
          end
          if (xfer_all) begin
            out_reg[c] <= (load_en && load_idx == c) ? load_code :
                                                       in_reg[c];
          end else if (out_one && load_idx == c) begin
            out_reg[c] <= load_code;
          end
        end
      end
    end
  endgenerate

  always_comb begin
    for (int k = 0; k < 16; k++) begin
      chan_out.gamma[k] = out_reg[k];
    end
    chan_out.vcom[0] = out_reg[PTR_VCOM_ONE[4:0]];
    chan_out.vcom[1] = out_reg[PTR_VCOM_TWO[4:0]];
  end
endmodule : gamma_target

// >>> test/gamma_target_chk.sv
// Concurrent property checker for the gamma reference serial target
`timescale 1ns/1ns
module gamma_target_chk
  import gamma_pkg::*;
#(
  parameter int BANK_LOAD_CYCLES = BANK_LOAD_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Serial link
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // Straps
  input wire logic address_select_pin,
  input wire logic bank_select_pin,
  // Channel codes and status
  input wire chan_out_s chan_out,
  input wire logic nvm_busy
);
  localparam int BUSY_MIN = 2500;
  localparam int BUSY_MAX = 2600;
  logic [11:0] busy_cnt_reg;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  // Length of the current programming interval
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) busy_cnt_reg <= 12'h000;
    else if (nvm_busy) busy_cnt_reg <= busy_cnt_reg + 12'h001;
    else busy_cnt_reg <= 12'h000;
  end

  property p_busy_min;
    $fell(nvm_busy) |-> busy_cnt_reg >= BUSY_MIN;
  endproperty
  a_busy_min: assert property (p_busy_min)
    else $error("programming interval too short");
  property p_busy_max;
    nvm_busy |-> busy_cnt_reg < BUSY_MAX;
  endproperty
  a_busy_max: assert property (p_busy_max)
    else $error("programming interval too long");
  // Ack of the committing byte may still stand early in the interval
  property p_busy_quiet;
    busy_cnt_reg >= 12'h010 |-> sda_oe_n;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data line driven while programming");
  property p_oe_scl_low;
    $changed(sda_oe_n) |-> !scl_in;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data line changed while clock high");
  property p_oe_hold;
    $fell(sda_oe_n) |-> !sda_oe_n [*4];
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data line drive too short");
  property p_bank_hold;
    $changed(bank_select_pin) |-> $stable(chan_out) [*8];
  endproperty
  a_bank_hold: assert property (p_bank_hold)
    else $error("outputs moved too soon after bank change");
  property p_reset_default;
    $rose(rstn) |-> chan_out == {18{CODE_DEFAULT}} ##1 $stable(chan_out);
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("outputs not at default after reset");
  property p_sda_zero;
    sda_out == 1'b0;
  endproperty
  a_sda_zero: assert property (p_sda_zero)
    else $error("open drain value not low");
endmodule : gamma_target_chk

// >>> test/i2c_master_model.sv
// Serial bus master model that talks to the gamma target
`timescale 1ns/1ns
module i2c_master_model (
  // Clock
  input wire logic clock,
  // Bus
  input wire logic sda_line,
  output logic scl_pin,
  output logic sda_drv
);
  int slow;

  initial begin
    scl_pin = 1'b1;
    sda_drv = 1'b1;
    slow = 0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick

  // Start or repeated start
  task automatic start();
    sda_drv <= 1'b1;
    tick(2);
    scl_pin <= 1'b1;
    tick(2);
    sda_drv <= 1'b0;
    tick(2);
    scl_pin <= 1'b0;
    tick(2);
  endtask : start

  task automatic stop();
    sda_drv <= 1'b0;
    tick(2);
    scl_pin <= 1'b1;
    tick(2);
    sda_drv <= 1'b1;
    tick(4);
  endtask : stop

  // One clock pulse; slow stretches the low phase
  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    tick(3 + slow);
    scl_pin <= 1'b1;
    tick(1);
    r = sda_line;
    tick(2);
    scl_pin <= 1'b0;
    tick(2);
  endtask : bit_io

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte

  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask : rbyte
endmodule : i2c_master_model

// >>> test/gamma_dac_i2c_nvm_access_tb.sv
// Self-checking bench for the gamma reference serial target
`timescale 1ns/1ns
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (g), (e)); \
  end \
end
module gamma_dac_i2c_nvm_access_tb
  import gamma_pkg::*;
;
  localparam int LOAD = 40;
  logic clock;
  logic rstn;
  logic address_select_pin;
  logic bank_select_pin;
  logic sda_out;
  logic sda_oe_n;
  logic nvm_busy;
  logic scl_pin;
  logic sda_drv;
  wire sda_line;
  chan_out_s chan_out;
  int num_errors;
  int compares;
  logic [6:0] dev;
  logic [7:0] acks;
  logic [15:0] rbuf [2];

  // Open drain wire with pull-up
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  gamma_target #(.BANK_LOAD_CYCLES(LOAD)) u_dut (
    .clock(clock), .rstn(rstn), .scl_in(scl_pin), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_pin(address_select_pin),
    .bank_select_pin(bank_select_pin), .chan_out(chan_out),
    .nvm_busy(nvm_busy)
  );
  i2c_master_model u_master (
    .clock(clock), .sda_line(sda_line), .scl_pin(scl_pin), .sda_drv(sda_drv)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic code_t code_of(input int i);
    return (i < 16) ? chan_out.gamma[i] : chan_out.vcom[i - 16];
  endfunction : code_of

  task automatic summarize();
    $display("compares=%0d errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize

  task automatic xfer(input logic [7:0] p, input logic [31:0] d,
                      input int nb);
    logic a;
    u_master.start();
    u_master.wbyte({dev, 1'b0}, a);
    acks = {7'h00, a};
    if (a) begin
      u_master.wbyte(p, a);
      acks = {acks[6:0], a};
    end
    for (int i = 0; i < nb && a; i++) begin
      u_master.wbyte(d[31 - 8 * i -: 8], a);
      acks = {acks[6:0], a};
    end
    u_master.stop();
  endtask : xfer

  task automatic rd(input logic [7:0] p, input int n);
    logic a;
    logic [7:0] hi;
    logic [7:0] lo;
    xfer(p, 32'h0000_0000, 0);
    u_master.start();
    u_master.wbyte({dev, 1'b1}, a);
    acks = {acks[6:0], a};
    for (int i = 0; i < n; i++) begin
      u_master.rbyte(1'b0, hi);
      u_master.rbyte(i == n - 1, lo);
      rbuf[i] = {hi, lo};
    end
    u_master.stop();
  endtask : rd

  task automatic wait_out(input int i, input code_t v, input int lim);
    int k;
    k = 0;
    while (code_of(i) !== v && k < lim) begin
      @(posedge clock);
      k++;
    end
    `CHK(code_of(i), v)
    if (k >= lim) summarize();
  endtask : wait_out

  task automatic wait_idle();
    int k;
    k = 0;
    while (nvm_busy !== 1'b0 && k < 4000) begin
      @(posedge clock);
      k++;
    end
    `CHK(nvm_busy, 1'b0)
    if (k >= 4000) summarize();
    u_master.tick(10);
  endtask : wait_idle

  task automatic t_power();
    u_master.tick(40);
    for (int i = 0; i < 18; i++) begin
      `CHK(code_of(i), 10'h200)
    end
    `CHK(nvm_busy, 1'b0)
  endtask : t_power

  task automatic t_addr();
    address_select_pin <= 1'b1;
    u_master.tick(4);
    xfer(8'h00, 32'h0, 0);
    `CHK(acks, 8'h00)
    dev = {DEV_ADDR_HI, 1'b1};
    xfer(8'h00, 32'h0, 0);
    `CHK(acks, 8'h03)
    address_select_pin <= 1'b0;
    dev = {DEV_ADDR_HI, 1'b0};
    u_master.tick(4);
  endtask : t_addr

  task automatic t_vol();
    xfer(8'h00, 32'h0155_0266, 4);
    `CHK(acks, 8'h3F)
    u_master.tick(20);
    `CHK(code_of(0), 10'h200)
    `CHK(code_of(1), 10'h200)
    xfer(8'h13, 32'h8377_0000, 2);
    wait_out(17, 10'h377, 100);
    `CHK(code_of(0), 10'h155)
    `CHK(code_of(1), 10'h266)
  endtask : t_vol

  task automatic t_read();
    logic [7:0] rp [6] = '{8'h10, 8'h11, 8'h14, 8'h17, 8'h3C, 8'h3D};
    logic [15:0] rv [6] = '{16'h0, 16'h0, 16'h0, 16'h0,
                            DIE_REV_VAL, DIE_ID_VAL};
    u_master.slow = 3;
    rd(8'h00, 2);
    `CHK(acks, 8'h07)
    `CHK(rbuf[0], 16'h0155)
    `CHK(rbuf[1], 16'h0266)
    u_master.slow = 0;
    for (int i = 0; i < 6; i++) begin
      rd(rp[i], 1);
      `CHK(rbuf[0], rv[i])
    end
  endtask : t_read

  task automatic t_nvm();
    xfer(8'h02, 32'h4123_4055, 4);
    `CHK(acks, 8'h1E)
    `CHK(nvm_busy, 1'b1)
    `CHK(code_of(2), 10'h123)
    xfer(8'h00, 32'h0, 0);
    `CHK(acks, 8'h00)
    wait_idle();
    xfer(8'h03, 32'h4100_0000, 1);
    `CHK(acks, 8'h07)
    `CHK(nvm_busy, 1'b0)
    xfer(8'h12, 32'h42AA_0000, 2);
    `CHK(code_of(16), 10'h2AA)
    wait_idle();
  endtask : t_nvm

  task automatic t_acq();
    xfer(8'h02, 32'h83FF_0000, 2);
    wait_out(2, 10'h3FF, 100);
    xfer(8'h42, 32'h0, 0);
    u_master.tick(300);
    `CHK(code_of(2), 10'h3FF)
    wait_out(2, 10'h123, 400);
    xfer(8'h03, 32'h8011_0000, 2);
    wait_out(3, 10'h011, 100);
    xfer(8'h80, 32'h0, 0);
    wait_out(3, 10'h200, 200);
    `CHK(code_of(16), 10'h2AA)
    `CHK(code_of(0), 10'h200)
    rd(8'h12, 1);
    `CHK(rbuf[0], 16'h02AA)
  endtask : t_acq

  task automatic t_bank();
    bank_select_pin <= 1'b1;
    u_master.tick(20);
    `CHK(code_of(2), 10'h123)
    wait_out(2, 10'h200, 200);
    `CHK(code_of(16), 10'h200)
    bank_select_pin <= 1'b0;
    wait_out(2, 10'h123, 200);
    `CHK(code_of(16), 10'h2AA)
  endtask : t_bank

  initial begin
    rstn = 1'b0;
    address_select_pin = 1'b0;
    bank_select_pin = 1'b0;
    dev = {DEV_ADDR_HI, 1'b0};
    num_errors = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    t_power();
    t_addr();
    t_vol();
    t_read();
    t_nvm();
    t_acq();
    t_bank();
    summarize();
  end
endmodule : gamma_dac_i2c_nvm_access_tb

bind gamma_target gamma_target_chk #(.BANK_LOAD_CYCLES(BANK_LOAD_CYCLES))
  u_chk (
  .clock(clock), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .address_select_pin(address_select_pin),
  .bank_select_pin(bank_select_pin), .chan_out(chan_out),
  .nvm_busy(nvm_busy)
);
